/* File: hdl/bsm_debounce.sv */
// Two-flop synchroniser and stability filter for the push buttons
`default_nettype none
module bsm_debounce #(
  parameter int W = 3,
  parameter int CNT = 4000000
)(
  input wire logic clk_sys_i, // System clock
  input wire logic rst_i, // Async reset, high
  input wire logic [W-1:0] raw_i, // Raw button pins
  output logic [W-1:0] level_o // Clean button levels
);
  localparam int CW = $clog2(CNT + 1);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] lvl;
    logic [W-1:0][CW-1:0] cnt;
  } bsm_deb_s;
  bsm_deb_s s;
  bsm_deb_s n;

  // Level flips only after the pin stays changed for CNT cycles
  always_comb
  begin
    n = s;
    n.s1 = raw_i;
    n.s2 = s.s1;
    for (int i = 0; i < W; i++)
    begin
      if (s.s2[i] == s.lvl[i])
        n.cnt[i] = '0;
      else if (s.cnt[i] == CW'(CNT - 1))
      begin
        n.lvl[i] = s.s2[i];
        n.cnt[i] = '0;
      end
      else
        n.cnt[i] = s.cnt[i] + 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      s <= '0;
    else
      s <= n;
  end

  assign level_o = s.lvl;
endmodule : bsm_debounce
`default_nettype wire

/* File: hdl/bsm_map.svh */
// Timing figures, limits, defaults and register offsets of the setup menu
`ifndef BSM_MAP_SVH
`define BSM_MAP_SVH
`define BSM_CLK_MHZ 200
`define BSM_DEB_MS 20
`define BSM_ENTER_MS 3000
`define BSM_EXIT_MS 3000
`define BSM_TRIM_MS 500
`define BSM_IDLE_MS 5000
`define BSM_REP_MS 200
`define BSM_MAGIC 16'h5a3c
`define BSM_W_DISP 4'h1
`define BSM_W_UNIT 4'h2
`define BSM_W_FLOOR 4'h3
`define BSM_W_CEIL 4'h4
`define BSM_W_PRES 4'h5
`define BSM_W_HB 4'h7
`define BSM_W_TB 4'h8
`define BSM_W_GB 4'h9
`define BSM_W_RATE 4'ha
`define BSM_W_SPEED 4'hb
`define BSM_W_CHECK 4'hc
`define BSM_W_ENDB 4'hd
`define BSM_W_SP 4'hf
`define BSM_FLOOR_DEF 16'h0014
`define BSM_FLOOR_MIN 16'h0000
`define BSM_CEIL_DEF 16'h0023
`define BSM_CEIL_MAX 16'h0032
`define BSM_SP_DEF 16'h0016
`define BSM_PRES_DEF 16'h03f5
`define BSM_PRES_MIN 16'h02a5
`define BSM_PRES_MAX 16'h03f8
`define BSM_PRES_US_STEP 16'h0003
`define BSM_HB_LIM 16'h012c
`define BSM_TB_LIM 16'h012c
`define BSM_GB_LIM 16'h01f4
`define BSM_RATE_DEF 16'h0001
`define BSM_SPEED_MAX 16'h0005
`define BSM_CHECK_MAX 16'h0002
`define BSM_DISP_MAX 16'h0007
`define BSM_F_MUL 32'h0000_0009
`define BSM_F_DIV 32'h0000_0005
`define BSM_F_OFS 32'h0000_0140
`define BSM_INHG_MUL 32'h0000_04ba
`define BSM_INHG_RND 32'h0000_0800
`define BSM_INHG_SH 12
`define BSM_A_STATUS 3'h0
`define BSM_A_SETPT 3'h1
`define BSM_A_CONFIG 3'h2
`define BSM_A_LIMITS 3'h3
`define BSM_A_PRES 3'h4
`define BSM_A_BIAS_A 3'h5
`define BSM_A_BIAS_B 3'h6
`define BSM_A_CTRL 3'h7
`endif

/* File: hdl/bsm_pkg.sv */
// Types shared by the setup menu design
`default_nettype none
package bsm_pkg;
  typedef enum logic [3:0] {
    IT_DISP, IT_UNIT, IT_FLOOR, IT_CEIL, IT_PRES, IT_TRIM, IT_HBIAS,
    IT_TBIAS, IT_GBIAS, IT_RATE, IT_SPEED, IT_CHECK, IT_ENDB, IT_RESTORE
  } bsm_item_e;
  typedef enum logic [2:0] {
    MD_LOAD, MD_HOME, MD_SETPT, MD_BROWSE, MD_EDIT, MD_TRIM
  } bsm_mode_e;
  typedef struct packed {
    logic [2:0] layout;
    logic us_units;
    logic edit_mark;
    logic menu_on;
    logic sp_view;
    logic [3:0] item;
    logic signed [15:0] value;
  } bsm_disp_s;
  typedef struct packed {
    logic signed [15:0] temp;
    logic signed [15:0] hum;
    logic signed [15:0] gas;
  } bsm_meas_s;
  typedef struct packed {
    logic auto_rate;
    logic [2:0] speed;
    logic [1:0] check;
    logic two_stop;
  } bsm_serial_s;
endpackage : bsm_pkg
`default_nettype wire

/* File: hdl/bsm_store.sv */
// Non-volatile parameter word store with registered read data
`default_nettype none
module bsm_store #(
  parameter int W = 16,
  parameter int D = 16,
  parameter int AW = $clog2(D)
)(
  input wire logic clk_sys_i, // System clock
  input wire logic we_i, // Write strobe
  input wire logic [AW-1:0] addr_i, // Word address
  input wire logic [W-1:0] wdata_i, // Write data
  output logic [W-1:0] rdata_o // Read data, one cycle late
);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [W-1:0] rd;
  } bsm_mem_s;
  bsm_mem_s s;
  bsm_mem_s n;

  // Contents are kept across resets on purpose
  always_comb
  begin
    n = s;
    n.rd = s.mem[addr_i];
    if (we_i)
      n.mem[addr_i] = wdata_i;
  end

  // Storage register
  always_ff @(posedge clk_sys_i)
  begin
    s <= n;
  end

  assign rdata_o = s.rd;
endmodule : bsm_store
`default_nettype wire

/* File: hdl/bsm_top.sv */
// Button-driven setup menu, parameter store and AHB-Lite status slave
//
// Overview of operation
// R1: Up and down held together 3 s on home screen enters menu.
// R2: In menu, up or down press steps to next or previous item.
// R3: Both pressed on an item enters edit, lights edit mark.
// R4: Both pressed again in edit stores value and leaves edit.
// R5: Down alone held 3 s in menu returns to home screen.
// R6: Display select picks one of eight home layouts.
// R7: Unit select gives metric or US units for shown values.
// R8: Floor defaults 20, steps 1, ranges 0 to ceiling.
// R9: Stored floor above set point raises set point to floor.
// R10: Ceiling defaults 35, steps 1, ranges floor to 50.
// R11: Stored ceiling below set point lowers set point to ceiling.
// R12: Holding up or down repeats steps while editing limits.
// R13: Pressure defaults 1013, 677 to 1016 hPa, unit-dependent step.
// R14: Humidity bias 0, plus or minus 30.0 %, added to humidity.
// R15: Temperature bias 0, plus or minus 30.0, added to temperature.
// R16: Gas bias 0, plus or minus 500 ppm, added to gas.
// R17: Rate detect on forces eight data bits, no parity, one stop.
// R18: Line speed six rates, visible only with rate detect off.
// R19: Parity choice none, even, odd, visible only with detect off.
// R20: Stop bits one or two, visible only with detect off.
// R21: Factory restore yes resets all settings, then resets device.
// R22: Gas trim: down 0.5 s captures zero, then up 0.5 s span.
// R23: Home up/down steps set point; 5 s idle saves, goes home.
// R24: Stored parameters kept in store and reloaded at power-on.
// R25: Buttons synchronised and debounced before hold timing.
//
// Local design decisions: the AHB-Lite register port and the register addresses.
`default_nettype none
`include "bsm_map.svh"
module bsm_top
  import bsm_pkg::*;
#(
  parameter int DEB_CYC = `BSM_DEB_MS * `BSM_CLK_MHZ * 1000,
  parameter int ENTER_CYC = `BSM_ENTER_MS * `BSM_CLK_MHZ * 1000,
  parameter int EXIT_CYC = `BSM_EXIT_MS * `BSM_CLK_MHZ * 1000,
  parameter int TRIM_CYC = `BSM_TRIM_MS * `BSM_CLK_MHZ * 1000,
  parameter int IDLE_CYC = `BSM_IDLE_MS * `BSM_CLK_MHZ * 1000,
  parameter int REP_CYC = `BSM_REP_MS * `BSM_CLK_MHZ * 1000
)(
  input wire logic clk_sys_i, // System clock
  input wire logic rst_i, // Async reset, high
  input wire logic up_btn_i, // Up button pin
  input wire logic mid_btn_i, // Middle button pin
  input wire logic down_btn_i, // Down button pin
  input wire bsm_meas_s meas_i, // Measured values
  input wire logic hsel_i, // AHB select
  input wire logic [31:0] haddr_i, // AHB address
  input wire logic [1:0] htrans_i, // AHB transfer type
  input wire logic hwrite_i, // AHB write
  input wire logic [2:0] hsize_i, // AHB size
  input wire logic [31:0] hwdata_i, // AHB write data
  input wire logic hready_i, // AHB ready in
  output logic [31:0] hrdata_o, // AHB read data
  output logic hreadyout_o, // AHB ready out
  output logic hresp_o, // AHB response
  output bsm_disp_s disp_o, // Display drive
  output bsm_meas_s shown_o, // Biased shown values
  output logic [15:0] pres_o, // Pressure, hPa or 0.1 inHg
  output bsm_serial_s serial_o, // Serial line setup
  output logic zero_cap_o, // Zero capture pulse
  output logic span_cap_o, // Span capture pulse
  output logic override_o, // Override pulse
  output logic dev_reset_o // Device reset pulse
);
  localparam logic [15:0][15:0] PW_DEF = {
    `BSM_SP_DEF, 16'h0000, 16'h0000, 16'h0000, 16'h0000, `BSM_RATE_DEF,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, `BSM_PRES_DEF, `BSM_CEIL_DEF,
    `BSM_FLOOR_DEF, 16'h0000, 16'h0000, `BSM_MAGIC};

  typedef struct packed {
    bsm_mode_e mode;
    bsm_item_e item;
    logic [15:0][15:0] pw;
    logic signed [15:0] ev;
    logic [1:0] prev;
    logic mid_prev;
    logic [29:0] hold;
    logic [29:0] rep;
    logic [29:0] idle;
    logic zero_done;
    logic [4:0] cnt;
    logic saving;
    logic save_req;
    logic restore_pend;
    logic menu_en;
    logic a_act;
    logic a_wr;
    logic [2:0] a_idx;
    logic [31:0] hrdata;
    bsm_disp_s disp;
    bsm_meas_s shown;
    logic [15:0] pres;
    bsm_serial_s serial;
    logic zcap;
    logic scap;
    logic ovr;
    logic devrst;
  } bsm_top_s;
  bsm_top_s s;
  bsm_top_s n;

  logic [2:0] btn_db;
  logic [1:0] btn;
  logic chg;
  logic up_ev;
  logic dn_ev;
  logic both_ev;
  logic rep_ev;
  logic [15:0] mem_rd;
  logic signed [15:0] sp;
  logic signed [31:0] tf;

  function automatic logic signed [15:0] bsm_clamp(
    input logic signed [15:0] v,
    input logic signed [15:0] lo,
    input logic signed [15:0] hi
  );
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : bsm_clamp

  function automatic logic [3:0] bsm_widx(input bsm_item_e it);
    return 4'(it) + 4'h1;
  endfunction : bsm_widx

  // Step an edited value within the item's range
  function automatic logic signed [15:0] bsm_step(
    input bsm_item_e it,
    input logic signed [15:0] v,
    input logic up,
    input logic [15:0][15:0] pw
  );
    logic signed [15:0] lo;
    logic signed [15:0] hi;
    logic signed [15:0] d;
    lo = 16'sh0000;
    hi = 16'sh0001;
    d = 16'sh0001;
    case (it)
      IT_DISP: hi = `BSM_DISP_MAX; // [R6]
      IT_FLOOR:
      begin
        lo = `BSM_FLOOR_MIN; // [R8]
        hi = pw[`BSM_W_CEIL];
      end
      IT_CEIL:
      begin
        lo = pw[`BSM_W_FLOOR];
        hi = `BSM_CEIL_MAX; // [R10]
      end
      IT_PRES:
      begin
        lo = `BSM_PRES_MIN; // [R13]
        hi = `BSM_PRES_MAX;
        if (pw[`BSM_W_UNIT][0])
          d = `BSM_PRES_US_STEP;
      end
      IT_HBIAS:
      begin
        lo = -`BSM_HB_LIM; // [R14]
        hi = `BSM_HB_LIM;
      end
      IT_TBIAS:
      begin
        lo = -`BSM_TB_LIM; // [R15]
        hi = `BSM_TB_LIM;
      end
      IT_GBIAS:
      begin
        lo = -`BSM_GB_LIM; // [R16]
        hi = `BSM_GB_LIM;
      end
      IT_SPEED: hi = `BSM_SPEED_MAX; // [R18]
      IT_CHECK: hi = `BSM_CHECK_MAX; // [R19]
      default: hi = 16'sh0001;
    endcase
    return bsm_clamp(up ? v + d : v - d, lo, hi);
  endfunction : bsm_step

  // Next or previous item, hiding serial items under rate detect
  function automatic bsm_item_e bsm_next(
    input bsm_item_e it,
    input logic up,
    input logic auto_rate
  );
    bsm_item_e r;
    if (up)
      r = (it == IT_RESTORE) ? IT_DISP : bsm_item_e'(4'(it) + 4'h1);
    else
      r = (it == IT_DISP) ? IT_RESTORE : bsm_item_e'(4'(it) - 4'h1);
    if (auto_rate && (r == IT_SPEED || r == IT_CHECK || r == IT_ENDB))
      r = up ? IT_RESTORE : IT_RATE; // [R18] [R19] [R20]
    return r;
  endfunction : bsm_next

  // Button conditioning
  bsm_debounce #(
    .W(3),
    .CNT(DEB_CYC)
  ) u_deb (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .raw_i({up_btn_i, mid_btn_i, down_btn_i}), // [R25]
    .level_o(btn_db)
  );

  // Parameter words survive reset here
  bsm_store #(
    .W(16),
    .D(16)
  ) u_store (
    .clk_sys_i(clk_sys_i),
    .we_i(s.saving),
    .addr_i(s.cnt[3:0]),
    .wdata_i(s.pw[s.cnt[3:0]]),
    .rdata_o(mem_rd)
  );

  // Button events and derived values
  assign btn = {btn_db[2], btn_db[0]};
  assign chg = btn != s.prev;
  assign up_ev = chg && btn == 2'b10;
  assign dn_ev = chg && btn == 2'b01;
  assign both_ev = chg && btn == 2'b11;
  assign rep_ev = !chg && btn != 2'b00 && s.rep == 30'(REP_CYC - 1);
  assign sp = s.pw[`BSM_W_SP];
  assign tf = 32'(meas_i.temp + s.pw[`BSM_W_TB]) * `BSM_F_MUL / `BSM_F_DIV + `BSM_F_OFS;

  // Next state
  always_comb
  begin
    n = s;
    n.zcap = 1'b0;
    n.scap = 1'b0;
    n.ovr = 1'b0;
    n.devrst = 1'b0;
    n.prev = btn;
    n.mid_prev = btn_db[1];
    if (chg || btn == 2'b00)
    begin
      n.hold = '0;
      n.rep = '0;
    end
    else
    begin
      if (~&s.hold)
        n.hold = s.hold + 30'h1;
      n.rep = rep_ev ? 30'h0 : s.rep + 30'h1;
    end
    if (btn_db[1] && !s.mid_prev && (s.mode == MD_HOME || s.mode == MD_SETPT))
      n.ovr = 1'b1;
    // Background save sweep of all words
    if (s.saving)
    begin
      n.cnt = s.cnt + 5'h1;
      if (s.cnt == 5'h0f)
      begin
        n.saving = 1'b0;
        n.cnt = '0;
        n.devrst = s.restore_pend; // [R21]
        n.restore_pend = 1'b0;
      end
    end
    else if (s.save_req && s.mode != MD_LOAD)
    begin
      n.saving = 1'b1; // [R24]
      n.save_req = 1'b0;
      n.cnt = '0;
    end
    case (s.mode)
      MD_LOAD:
      begin
        n.cnt = s.cnt + 5'h1;
        if (s.cnt != 5'h00)
          n.pw[4'(s.cnt - 5'h1)] = mem_rd; // [R24]
        // Blank or unknown store contents fall back to defaults
        if (s.cnt == 5'h01 && mem_rd == `BSM_MAGIC)
          n.mode = MD_LOAD;
        else if (s.cnt == 5'h01)
        begin
          n.pw = PW_DEF;
          n.save_req = 1'b1;
          n.cnt = '0;
          n.mode = MD_HOME;
        end
        else if (s.cnt == 5'h10)
        begin
          n.cnt = '0;
          n.mode = MD_HOME;
        end
      end
      MD_HOME:
      begin
        if (up_ev || dn_ev)
        begin
          n.mode = MD_SETPT;
          n.idle = '0;
        end
        else if (btn == 2'b11 && s.menu_en && s.hold == 30'(ENTER_CYC - 1))
        begin
          n.mode = MD_BROWSE; // [R1]
          n.item = IT_DISP;
        end
      end
      MD_SETPT:
      begin
        n.idle = s.idle + 30'h1;
        if (up_ev || dn_ev || rep_ev)
        begin
          n.idle = '0;
          n.pw[`BSM_W_SP] = bsm_clamp(sp + (btn[1] ? 16'sh1 : -16'sh1),
            s.pw[`BSM_W_FLOOR], s.pw[`BSM_W_CEIL]); // [R23]
        end
        else if (btn != 2'b00)
          n.idle = '0;
        else if (s.idle == 30'(IDLE_CYC - 1))
        begin
          n.mode = MD_HOME; // [R23]
          n.save_req = 1'b1;
        end
      end
      MD_BROWSE:
      begin
        if (up_ev || dn_ev)
          n.item = bsm_next(s.item, up_ev, s.pw[`BSM_W_RATE][0]); // [R2]
        else if (both_ev && s.item == IT_TRIM)
        begin
          n.mode = MD_TRIM;
          n.zero_done = 1'b0;
        end
        else if (both_ev)
        begin
          n.mode = MD_EDIT; // [R3]
          n.ev = s.pw[bsm_widx(s.item)];
        end
        else if (btn == 2'b01 && s.hold == 30'(EXIT_CYC - 1))
          n.mode = MD_HOME; // [R5]
      end
      MD_EDIT:
      begin
        if (up_ev || dn_ev)
          n.ev = bsm_step(s.item, s.ev, up_ev, s.pw); // [R3]
        else if (rep_ev && (s.item == IT_FLOOR || s.item == IT_CEIL))
          n.ev = bsm_step(s.item, s.ev, btn[1], s.pw); // [R12]
        else if (both_ev)
        begin
          n.mode = MD_BROWSE;
          n.save_req = 1'b1;
          n.pw[bsm_widx(s.item)] = s.ev; // [R4]
          if (s.item == IT_FLOOR && s.ev > sp)
            n.pw[`BSM_W_SP] = s.ev; // [R9]
          if (s.item == IT_CEIL && s.ev < sp)
            n.pw[`BSM_W_SP] = s.ev; // [R11]
          if (s.item == IT_RESTORE && s.ev != 16'sh0)
          begin
            n.pw = PW_DEF; // [R21]
            n.restore_pend = 1'b1;
          end
        end
      end
      MD_TRIM:
      begin
        if (btn == 2'b01 && s.hold == 30'(TRIM_CYC - 1))
        begin
          n.zcap = 1'b1; // [R22]
          n.zero_done = 1'b1;
        end
        else if (btn == 2'b10 && s.zero_done && s.hold == 30'(TRIM_CYC - 1))
        begin
          n.scap = 1'b1; // [R22]
          n.mode = MD_BROWSE;
        end
      end
      default: n.mode = MD_HOME;
    endcase
    // Bus data phase: writes to set point and control
    if (s.a_act && s.a_wr)
    begin
      if (s.a_idx == `BSM_A_SETPT)
      begin
        n.pw[`BSM_W_SP] = bsm_clamp(hwdata_i[15:0],
          s.pw[`BSM_W_FLOOR], s.pw[`BSM_W_CEIL]);
        n.save_req = 1'b1;
      end
      else if (s.a_idx == `BSM_A_CTRL)
        n.menu_en = hwdata_i[0];
    end
    // Bus address phase: capture and read answer
    n.a_act = hsel_i && hready_i && htrans_i[1] && haddr_i[31:5] == 27'h0;
    n.a_wr = hwrite_i;
    n.a_idx = haddr_i[4:2];
    n.hrdata = 32'h0;
    if (n.a_act && !hwrite_i)
    begin
      case (haddr_i[4:2])
        `BSM_A_STATUS: n.hrdata = {19'h0, s.menu_en, s.saving, s.mode, 4'(s.item), 1'b0,
          s.disp.edit_mark, s.disp.menu_on, s.disp.sp_view};
        `BSM_A_SETPT: n.hrdata = {16'h0, s.pw[`BSM_W_SP]};
        `BSM_A_CONFIG: n.hrdata = {21'h0, s.pw[`BSM_W_ENDB][0],
          s.pw[`BSM_W_CHECK][1:0], s.pw[`BSM_W_SPEED][2:0], s.pw[`BSM_W_RATE][0],
          s.pw[`BSM_W_UNIT][0], s.pw[`BSM_W_DISP][2:0]};
        `BSM_A_LIMITS: n.hrdata = {s.pw[`BSM_W_CEIL], s.pw[`BSM_W_FLOOR]};
        `BSM_A_PRES: n.hrdata = {16'h0, s.pw[`BSM_W_PRES]};
        `BSM_A_BIAS_A: n.hrdata = {s.pw[`BSM_W_TB], s.pw[`BSM_W_HB]};
        `BSM_A_BIAS_B: n.hrdata = {16'h0, s.pw[`BSM_W_GB]};
        `BSM_A_CTRL: n.hrdata = {31'h0, s.menu_en};
        default: n.hrdata = 32'h0;
      endcase
    end
    // Display, shown values and serial setup
    n.disp.layout = s.pw[`BSM_W_DISP][2:0]; // [R6]
    n.disp.us_units = s.pw[`BSM_W_UNIT][0]; // [R7]
    n.disp.edit_mark = s.mode == MD_EDIT; // [R3]
    n.disp.menu_on = s.mode == MD_BROWSE || s.mode == MD_EDIT || s.mode == MD_TRIM;
    n.disp.sp_view = s.mode == MD_SETPT;
    n.disp.item = 4'(s.item);
    n.disp.value = (s.mode == MD_EDIT) ? s.ev :
      ((s.mode == MD_SETPT) ? sp : s.pw[bsm_widx(s.item)]);
    n.shown.hum = meas_i.hum + s.pw[`BSM_W_HB]; // [R14]
    n.shown.gas = meas_i.gas + s.pw[`BSM_W_GB]; // [R16]
    n.shown.temp = meas_i.temp + s.pw[`BSM_W_TB]; // [R15]
    if (s.pw[`BSM_W_UNIT][0])
    begin
      n.shown.temp = 16'(tf); // [R7]
      n.pres = 16'((32'(s.pw[`BSM_W_PRES]) * `BSM_INHG_MUL + `BSM_INHG_RND)
        >> `BSM_INHG_SH); // [R13]
    end
    else
      n.pres = s.pw[`BSM_W_PRES];
    n.serial.auto_rate = s.pw[`BSM_W_RATE][0];
    n.serial.speed = s.pw[`BSM_W_SPEED][2:0]; // [R18]
    n.serial.check = s.pw[`BSM_W_RATE][0] ? 2'h0 : s.pw[`BSM_W_CHECK][1:0]; // [R17]
    n.serial.two_stop = !s.pw[`BSM_W_RATE][0] && s.pw[`BSM_W_ENDB][0]; // [R20]
  end

  // State register
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s <= '0;
      s.mode <= MD_LOAD;
      s.pw <= PW_DEF;
      s.menu_en <= 1'b1;
    end
    else
      s <= n;
  end

  assign hrdata_o = s.hrdata;
  assign hreadyout_o = !rst_i || 1'b1;
  assign hresp_o = 1'b0;
  assign disp_o = s.disp;
  assign shown_o = s.shown;
  assign pres_o = s.pres;
  assign serial_o = s.serial;
  assign zero_cap_o = s.zcap;
  assign span_cap_o = s.scap;
  assign override_o = s.ovr;
  assign dev_reset_o = s.devrst;
endmodule : bsm_top
`default_nettype wire

/* File: hdl/bsm_unused.sv */
// (intentionally empty)

/* File: tb/bsm_panel.sv */
// Front-panel button model with contact bounce
`default_nettype none
module bsm_panel (
  input wire logic clk_sys_i, // System clock
  output logic up_btn_o, // Up contact
  output logic mid_btn_o, // Middle contact
  output logic down_btn_o // Down contact
);
  timeunit 1ns;
  timeprecision 100ps;
  // Contacts open at start
  initial
    {up_btn_o, mid_btn_o, down_btn_o} = 3'h0;
  // Press {up,mid,down}, bounce once, hold, release and rest
  task automatic push(input logic [2:0] pat, input int hold);
    {up_btn_o, mid_btn_o, down_btn_o} <= pat;
    @(posedge clk_sys_i);
    {up_btn_o, mid_btn_o, down_btn_o} <= 3'h0; // Bounce below filter time
    @(posedge clk_sys_i);
    {up_btn_o, mid_btn_o, down_btn_o} <= pat;
    repeat (hold) @(posedge clk_sys_i); // Held contact
    {up_btn_o, mid_btn_o, down_btn_o} <= 3'h0;
    repeat (12) @(posedge clk_sys_i);
  endtask : push
endmodule : bsm_panel
`default_nettype wire

/* File: tb/bsm_top_props.sv */
// Concurrent checks on the setup menu ports
`default_nettype none
module bsm_top_props
  import bsm_pkg::*;
#(
  parameter int ENTER_CYC = 200
)(
  input wire logic clk_sys_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic up_btn_i, // Up pin
  input wire logic down_btn_i, // Down pin
  input wire logic hsel_i, // Select
  input wire logic [31:0] haddr_i, // Address
  input wire logic [1:0] htrans_i, // Transfer
  input wire logic hwrite_i, // Write
  input wire logic hready_i, // Ready in
  input wire logic [31:0] hrdata_o, // Read data
  input wire logic hreadyout_o, // Ready out
  input wire logic hresp_o, // Response
  input wire bsm_disp_s disp_o, // Display
  input wire bsm_serial_s serial_o, // Serial setup
  input wire logic zero_cap_o, // Zero capture
  input wire logic span_cap_o, // Span capture
  input wire logic dev_reset_o // Device reset
);
  logic [15:0] both_cnt;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // Raw cycles with up and down held together
  always_ff @(posedge clk_sys_i or posedge rst_i)
    if (rst_i)
      both_cnt <= 16'h0000;
    else if (!(up_btn_i && down_btn_i))
      both_cnt <= 16'h0000;
    else if (both_cnt != 16'hffff)
      both_cnt <= both_cnt + 16'h0001;
  // Read of the limit word and its data phase
  sequence lim_rd;
    hsel_i && hready_i && htrans_i[1] && !hwrite_i && haddr_i == 32'h0000_000c;
  endsequence
  sequence lim_ok;
    hrdata_o[15:0] <= hrdata_o[31:16] && hrdata_o[31:16] <= 16'h0032;
  endsequence
  bus_okay_a: assert property (hreadyout_o && !hresp_o)
    else $error("bus answer not ready or not okay");
  menu_entry_a: assert property ($rose(disp_o.menu_on) |-> both_cnt >= ENTER_CYC)
    else $error("menu opened before a full hold");
  limit_order_a: assert property (lim_rd |=> lim_ok)
    else $error("limits out of order");
  edit_in_menu_a: assert property (disp_o.edit_mark |-> disp_o.menu_on)
    else $error("edit mark outside menu");
  auto_frame_a: assert property (serial_o.auto_rate |-> !serial_o.check && !serial_o.two_stop)
    else $error("auto rate without fixed frame");
  speed_code_a: assert property (serial_o.speed <= 3'h5)
    else $error("line speed code out of range");
  parity_code_a: assert property (serial_o.check != 2'h3)
    else $error("parity code out of range");
  reset_pulse_a: assert property (dev_reset_o |=> !dev_reset_o)
    else $error("device reset not a pulse");
  trim_pulse_a: assert property (zero_cap_o |-> !span_cap_o ##1 !zero_cap_o)
    else $error("capture pulses overlap");
  setpt_view_a: assert property (disp_o.sp_view |-> !disp_o.menu_on)
    else $error("set point view inside menu");
endmodule : bsm_top_props
bind bsm_top bsm_top_props #(.ENTER_CYC(ENTER_CYC)) u_props (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .up_btn_i(up_btn_i), .down_btn_i(down_btn_i),
  .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
  .hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
  .disp_o(disp_o), .serial_o(serial_o), .zero_cap_o(zero_cap_o), .span_cap_o(span_cap_o),
  .dev_reset_o(dev_reset_o));
`default_nettype wire

/* File: tb/bsm_top_tb_top.sv */
// Self-checking bench for the setup menu
`default_nettype none
module bsm_top_tb_top
  import bsm_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int ENTER = 200;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, hrdata;
  logic up, mid, down, hrdy, hresp, zcap, scap, ovr, dres;
  logic [15:0] pres;
  bsm_meas_s meas = {16'h00fa, 16'h01c7, 16'h0320};
  bsm_meas_s shown;
  bsm_disp_s disp;
  bsm_serial_s ser;
  int n_mismatch = 0;
  int n_checks = 0;
  int n_ovr = 0;
  int n_dres = 0;
  // 200 MHz clock
  always #2.5 clk_sys_i = ~clk_sys_i;
  // Count one-cycle pulses while they stand
  always @(posedge clk_sys_i)
  begin
    n_ovr <= n_ovr + int'(ovr === 1'b1);
    n_dres <= n_dres + int'(dres === 1'b1);
  end
  bsm_panel panel (.clk_sys_i(clk_sys_i), .up_btn_o(up), .mid_btn_o(mid), .down_btn_o(down));
  bsm_top #(.DEB_CYC(4), .ENTER_CYC(ENTER), .EXIT_CYC(200), .TRIM_CYC(50), .IDLE_CYC(300),
    .REP_CYC(20)) uut (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .up_btn_i(up), .mid_btn_i(mid), .down_btn_i(down),
    .meas_i(meas), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hrdy), .hrdata_o(hrdata), .hreadyout_o(hrdy),
    .hresp_o(hresp), .disp_o(disp), .shown_o(shown), .pres_o(pres), .serial_o(ser),
    .zero_cap_o(zcap), .span_cap_o(scap), .override_o(ovr), .dev_reset_o(dres));
  // Verdict and end of run
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : stop_test
  // Compare and count
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Bounded wait for ready at a rising edge
  task automatic rdy_wait;
    int n = 0;
    @(posedge clk_sys_i);
    while (hrdy !== 1'b1)
    begin
      if (++n > 50)
      begin
        n_mismatch++;
        stop_test;
      end
      @(posedge clk_sys_i);
    end
  endtask : rdy_wait
  // Single word transfer, read data taken at the closing edge
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hsize <= 3'h2;
    haddr <= a;
    hwrite <= w;
    rdy_wait();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy_wait();
    rd = hrdata;
  endtask : ahb
  task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    chk({16'h0, rd}, {16'h0, exp});
  endtask : rdchk
  // Hang guard
  initial
  begin
    repeat (100000) @(posedge clk_sys_i);
    n_mismatch++;
    stop_test;
  end
  // Main sequence
  initial
  begin
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    repeat (30) @(posedge clk_sys_i);
    rdchk(32'h08, 32'h10);
    chk({41'h0, ser}, 48'h40);
    rdchk(32'h0c, 32'h0023_0014);
    rdchk(32'h10, 32'h03f5);
    rdchk(32'h14, 32'h0);
    rdchk(32'h18, 32'h0);
    rdchk(32'h40, 32'h0);
    chk(shown, meas);
    chk(pres, 48'h3f5);
    meas.gas <= 16'hffce;
    repeat (3) @(posedge clk_sys_i);
    chk(shown, meas);
    ahb(1'b1, 32'h04, 32'h3c);
    rdchk(32'h04, 32'h23);
    ahb(1'b1, 32'h04, 32'h16);
    panel.push(3'h4, 10);
    chk(disp.sp_view, 48'h1);
    panel.push(3'h4, 10);
    repeat (330) @(posedge clk_sys_i);
    chk(disp.sp_view, 48'h0);
    rdchk(32'h04, 32'h17);
    panel.push(3'h2, 10);
    chk(48'(n_ovr), 48'h1);
    panel.push(3'h5, ENTER + 30);
    chk({disp.menu_on, disp.item}, 48'h10);
    panel.push(3'h4, 10);
    panel.push(3'h4, 10);
    panel.push(3'h1, 10);
    chk(disp.item, 48'h1);
    panel.push(3'h4, 10);
    panel.push(3'h5, 10);
    chk({disp.edit_mark, disp.item}, 48'h12);
    panel.push(3'h4, 400);
    chk(disp.value, 48'h23);
    repeat (10) panel.push(3'h1, 10);
    panel.push(3'h5, 10);
    chk(disp.edit_mark, 48'h0);
    rdchk(32'h0c, 32'h0023_0019);
    rdchk(32'h04, 32'h19);
    panel.push(3'h4, 10);
    panel.push(3'h5, 10);
    ahb(1'b1, 32'h04, 32'h21);
    panel.push(3'h1, 400);
    chk(disp.value, 48'h19);
    panel.push(3'h5, 10);
    rdchk(32'h0c, 32'h0019_0019);
    rdchk(32'h04, 32'h19);
    panel.push(3'h1, 10);
    panel.push(3'h1, 10);
    panel.push(3'h5, 10);
    panel.push(3'h4, 10);
    panel.push(3'h5, 10);
    chk(disp.us_units, 48'h1);
    chk(shown.temp, 48'h0302);
    chk(pres, 48'h12b);
    panel.push(3'h1, 10);
    panel.push(3'h1, 10);
    panel.push(3'h5, 10);
    panel.push(3'h4, 10);
    panel.push(3'h5, 10);
    rdchk(32'h04, 32'h16);
    panel.push(3'h1, 230);
    chk(disp.menu_on, 48'h0);
    chk(48'(n_dres), 48'h1);
    stop_test;
  end
endmodule : bsm_top_tb_top
`default_nettype wire
